// ==== dv/lpddr2_bst_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpddr2_bst_host (
  // Clock
  input  wire logic                    pclk,
  // Command word and write beats
  output var lpddr2_bst_pkg::ca_word_t cmd_in,
  output var lpddr2_bst_pkg::wr_pair_t wr_in
);
  import lpddr2_bst_pkg::*;
  // ****************************************
  // Controller side, one queued word per edge
  // ****************************************
  ca_word_t cq[$];
  wr_pair_t dq[$];
  // Deselected at time zero
  initial
  begin
    cmd_in = '1;
    wr_in  = '0;
  end
  // Idle lines invert each cycle so no stale value passes for data
  always @(posedge pclk)
  begin
    cmd_in <= cq.size() ? cq.pop_front() :
              {1'b1, ~cmd_in.ca_r, ~cmd_in.ca_f};
    wr_in  <= dq.size() ? dq.pop_front() : ~wr_in;
  end
endmodule : lpddr2_bst_host
`default_nettype wire

// ==== dv/lpddr2_bst_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpddr2_bst_monitor (
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // Watched ports
  input wire lpddr2_bst_pkg::ca_word_t cmd_in,
  input wire lpddr2_bst_pkg::arr_wr_t  arr_wr,
  input wire logic [7:0]               bank_open,
  input wire logic                     prech_strobe,
  input wire logic                     rd_data_window,
  input wire logic                     wr_data_window
);
  import lpddr2_bst_pkg::*;
  // ****************************************
  // Command decode and timing checks
  // ****************************************
  wire logic       sel = !cmd_in.cs_n;
  wire logic [3:0] op  = cmd_in.ca_r[3:0];
  wire logic [2:0] ba  = cmd_in.ca_r[9:7];
  wire logic       ap  = cmd_in.ca_f[0];
  wire logic       pre = sel && op == 4'hB;
  wire logic       bst = sel && op == 4'h3;
  wire logic       rd  = sel && op[2:0] == 3'h5;
  wire logic       wr  = sel && op[2:0] == 3'h1;
  wire logic       act = sel && op[1:0] == 2'h2;
  wire logic [7:0] cut = 8'h01 << ba;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pre_strobe; pre |=> prech_strobe; endproperty
  a_pre_strobe: assert property (p_pre_strobe)
    else $error("no precharge strobe");
  property p_pre_all; pre && cmd_in.ca_r[4] |=> bank_open == 8'h00; endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("bank left open");
  property p_pre_one;
    pre && !cmd_in.ca_r[4] |=> bank_open == ($past(bank_open) & ~$past(cut));
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("wrong bank closed");
  property p_act; act |=> bank_open[$past(ba)]; endproperty
  a_act: assert property (p_act)
    else $error("bank not opened");
  sequence s_bst2(logic c); bst && $past(c, 2) && !$past(ap, 2); endsequence
  property p_bst_wr;
    s_bst2(wr) |-> ##3 wr_data_window ##1 !wr_data_window;
  endproperty
  a_bst_wr: assert property (p_bst_wr)
    else $error("write not cut");
  property p_bst_rd;
    s_bst2(rd) |-> ##6 rd_data_window ##1 !rd_data_window;
  endproperty
  a_bst_rd: assert property (p_bst_rd)
    else $error("read not cut");
  property p_grp; wr && !ap |-> ##6 arr_wr.valid ##1 !arr_wr.valid; endproperty
  a_grp: assert property (p_grp)
    else $error("group write late");
  property p_ac_rd; rd && ap |-> ##4 !prech_strobe ##1 prech_strobe; endproperty
  a_ac_rd: assert property (p_ac_rd)
    else $error("read auto close");
  property p_ac_wr; wr && ap |-> ##14 !prech_strobe ##1 prech_strobe; endproperty
  a_ac_wr: assert property (p_ac_wr)
    else $error("write auto close");
  // Main scenarios
  c_bst: cover property (s_bst2(wr));
  c_all: cover property (pre && cmd_in.ca_r[4]);
  c_ac: cover property (rd && ap);
endmodule : lpddr2_bst_monitor
bind lpddr2_bst_ctrl lpddr2_bst_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .cmd_in(cmd_in), .arr_wr(arr_wr), .bank_open(bank_open),
  .prech_strobe(prech_strobe), .rd_data_window(rd_data_window),
  .wr_data_window(wr_data_window));
`default_nettype wire

// ==== dv/tb_lpddr2_bst_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_lpddr2_bst_ctrl;
  import lpddr2_bst_pkg::*;
  // ****************************************
  // Bench, reference model and scenarios
  // ****************************************
  localparam logic [3:0] ACT = 4'h2, RD = 4'h5, WR = 4'h1;
  localparam logic [3:0] BST = 4'h3, PRE = 4'hB;
  localparam int WL = CFG_RST[11:8], RL = CFG_RST[7:4], HALF = 4;
  localparam int RTP = CFG_RST[15:12], WRITE_RECOVERY_TIME = CFG_RST[19:16];
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, pw;
  logic        prech_strobe, rd_data_window, wr_data_window, lw, bok = 0;
  logic        exp_pre = 0, exp_ww = 0, exp_rw = 0;
  logic [7:0]  bank_open, exp_open = 0;
  logic [2:0]  ab, wb;
  logic [35:0] bq[$];
  ca_word_t    cmd_in;
  wr_pair_t    wr_in;
  arr_wr_t     arr_wr, exp_arr = '0;
  int          n_mismatch = 0, n_tests = 0, seed, cyc = 0, i;
  int          t = 0, lt = 0, w_on = 0, w_off = 0, r_on = 0, r_off = 0;
  int          ac = 0, nb = 0;
  // Clock
  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  lpddr2_bst_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_in(cmd_in),
    .wr_in(wr_in), .arr_wr(arr_wr), .bank_open(bank_open),
    .prech_strobe(prech_strobe), .rd_data_window(rd_data_window),
    .wr_data_window(wr_data_window));
  lpddr2_bst_host u_host (.pclk(pclk), .cmd_in(cmd_in), .wr_in(wr_in));
  // Helpers
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd
  task automatic chk(input logic [147:0] got, input logic [147:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Queue one command and gap idle cycles, random beats throughout
  task automatic slot(input logic [3:0] op, input logic [2:0] b,
                      input logic fl, input logic ap, input int gap);
    u_host.cq.push_back({1'b0, b, 2'(rnd()), fl, op, 9'(rnd()), ap});
    for (int g = 0; g <= gap; g++)
    begin
      u_host.dq.push_back(72'({rnd(), rnd(), rnd()}));
      if (g > 0)
        u_host.cq.push_back({1'b1, 20'(rnd())});
    end
  endtask : slot
  // Model step for a selected command word
  task automatic step();
    logic [3:0] op;
    logic [2:0] b;
    int k;
    op = cmd_in.ca_r[3:0];
    b = cmd_in.ca_r[9:7];
    k = t - lt;
    if (op[1:0] == 2'h2)
      exp_open[b] = 1'b1;
    if (op == PRE)
    begin
      exp_pre = 1'b1;
      exp_open = cmd_in.ca_r[4] ? 8'h00 : exp_open & ~(8'h01 << b);
    end
    if (op == BST && bok && k % 2 == 0 && k >= 2 && k <= HALF - 1)
    begin
      bok = 0;
      nb++;
      if (lw) w_off = t + WL; else r_off = t + RL;
    end
    if (op[2:0] == 3'h1 || op[2:0] == 3'h5)
    begin
      lt = t;
      lw = !op[2];
      bok = !cmd_in.ca_f[0];
      if (lw && t + WL > w_off) w_on = t + WL;
      if (!lw && t + RL > r_off) r_on = t + RL;
      if (lw) w_off = t + WL + HALF; else r_off = t + RL + HALF;
      if (lw) wb = b;
      if (cmd_in.ca_f[0]) ab = b;
      if (cmd_in.ca_f[0])
        ac = lw ? WL + HALF + 1 + WRITE_RECOVERY_TIME : (RTP > 2 ? HALF - 2 + RTP : HALF);
    end
  endtask : step
  // Compare the registered outputs, then advance the model by one edge
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
    if (presetn)
    begin
      chk(bank_open, exp_open);
      chk(prech_strobe, exp_pre);
      chk(rd_data_window, exp_rw);
      chk(wr_data_window, exp_ww);
      chk(arr_wr.valid, exp_arr.valid);
      if (exp_arr.valid)
        chk(arr_wr, exp_arr);
      exp_pre = 0;
      exp_arr.valid = 0;
      if (exp_ww)
      begin
        bq.push_back({wr_in.data_r, ~wr_in.mask_r});
        bq.push_back({wr_in.data_f, ~wr_in.mask_f});
      end
      if (bq.size() == 4)
      begin
        exp_arr = {1'b1, wb, bq[0][35:4], bq[1][35:4], bq[2][35:4],
          bq[3][35:4], bq[0][3:0], bq[1][3:0], bq[2][3:0], bq[3][3:0]};
        bq.delete();
      end
      if (ac == 1) exp_open[ab] = 0;
      if (ac == 1) exp_pre = 1;
      if (ac > 0) ac--;
      if (!cmd_in.cs_n) step();
      exp_ww = t >= w_on && t < w_off;
      exp_rw = t >= r_on && t < r_off;
      t++;
    end
  end
  // Main sequence
  initial
  begin
    seed = 32'h52fad1a2;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    pw = rnd();
    apb(1, 12'h000, pw);
    apb(0, 12'h000, 32'h0);
    chk(rdv, {12'h000, pw[19:0]});
    apb(1, 12'h000, CFG_RST);
    apb(0, 12'h000, 32'h0);
    chk(rdv, CFG_RST);
    apb(1, 12'h0FC, pw);
    chk({err, rdv}, {1'b1, 32'h0});
    apb(0, 12'h000, 32'h0);
    chk(rdv, CFG_RST);
    @(negedge pclk);
    for (i = 0; i < 8; i++) slot(ACT, i[2:0], 0, 0, 1);
    slot(WR, 1, 0, 0, 12);
    slot(WR, 2, 0, 0, 1);
    slot(BST, 0, 0, 0, 1);
    slot(BST, 0, 0, 0, 10);
    slot(RD, 3, 0, 0, 2);
    slot(BST, 0, 0, 0, 12);
    slot(RD, 4, 0, 0, 3);
    slot(RD, 5, 0, 0, 1);
    slot(BST, 0, 0, 0, 14);
    slot(RD, 3, 0, 1, 1);
    slot(BST, 0, 0, 0, 8);
    slot(WR, 2, 0, 1, 20);
    for (i = 0; i < 8; i++)
    begin
      slot(PRE, i[2:0], 0, 0, 1);
      slot(ACT, i[2:0], 0, 0, 1);
    end
    slot(PRE, 3'(rnd()), 1, 0, 4);
    while (u_host.cq.size() > 0) @(posedge pclk);
    repeat (20) @(posedge pclk);
    apb(0, 12'h008, 32'h0);
    chk(rdv[7:0], 8'(nb));
    apb(0, 12'h004, 32'h0);
    chk(rdv[7:0], exp_open);
    stop_test();
  end
endmodule : tb_lpddr2_bst_ctrl
`default_nettype wire

// ==== logic/lpddr2_bst_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpddr2_bst_ctrl #(
  parameter int NUM_BANKS = 8
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic [11:0]               paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Command and write data from the controller
  input  wire lpddr2_bst_pkg::ca_word_t  cmd_in,
  input  wire lpddr2_bst_pkg::wr_pair_t  wr_in,
  // Array side and status
  output lpddr2_bst_pkg::arr_wr_t        arr_wr,
  output logic [7:0]                     bank_open,
  output logic                           prech_strobe,
  output logic                           rd_data_window,
  output logic                           wr_data_window
);
  import lpddr2_bst_pkg::*;

  if (NUM_BANKS != NBANK) begin : g_chk
    $error("Only eight banks are supported");
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire logic             cs     = !cmd_in.cs_n;
  wire logic             is_act = cs & !cmd_in.ca_r[0] & cmd_in.ca_r[1];
  wire logic             is_rw  = cs & cmd_in.ca_r[0] & !cmd_in.ca_r[1];
  wire logic             is_rd  = is_rw & cmd_in.ca_r[2];
  wire logic             is_bst = cs & cmd_in.ca_r[0] & cmd_in.ca_r[1]
                                  & !cmd_in.ca_r[2] & !cmd_in.ca_r[3]; // [RULE_01]
  wire logic             is_pre = cs & cmd_in.ca_r[0] & cmd_in.ca_r[1]
                                  & !cmd_in.ca_r[2] & cmd_in.ca_r[3];  // [RULE_11]
  wire logic [BANK_W-1:0] cmd_bank   = cmd_in.ca_r[9:7];               // [RULE_12]
  wire logic             all_bank_flag  = cmd_in.ca_r[4];              // [RULE_12]
  wire logic             auto_close_bit = cmd_in.ca_f[0];              // [RULE_23]

  // ****************************************************************
  // Configuration fields
  // ****************************************************************
  logic [31:0] cfg_q;
  wire logic [1:0] bl_code = cfg_q[CFG_BL_LSB +: 2];
  wire logic [3:0] rl      = cfg_q[CFG_RL_LSB +: 4];
  wire logic [3:0] wl      = cfg_q[CFG_WL_LSB +: 4];
  wire logic [3:0] rtp     = cfg_q[CFG_RTP_LSB +: 4];
  wire logic [3:0] wr_rec  = cfg_q[CFG_WR_LSB +: 4];
  wire logic [4:0] half_prog = (bl_code == BL_CODE_4) ? 5'h02 :
                               (bl_code == BL_CODE_8) ? 5'h04 : 5'h08;

  // ****************************************************************
  // Most recent burst tracker
  // ****************************************************************
  logic              live_q, is_wr_q, ap_q, bst_done_q;
  logic [BANK_W-1:0] bank_q;
  logic [5:0]        cyc_q;
  logic [4:0]        eff_half_q;
  logic [7:0]        bst_cnt_q;

  // Stop accepted: even offset, within BL/2 - 1, once per burst
  wire logic bst_ok = is_bst & live_q & !bst_done_q & !ap_q     // [RULE_08]
                      & !cyc_q[0] & (cyc_q != 6'h00)            // [RULE_07]
                      & ({1'b0, cyc_q} < {2'b00, half_prog});   // [RULE_02]
  wire logic [5:0] cyc_d = is_rw ? 6'h01 :
                           (cyc_q == CYC_MAX) ? CYC_MAX : cyc_q + 6'h01;
  // New command resets the length; a stop sets it to the elapsed clocks
  wire logic [4:0] eff_half_d = is_rw ? half_prog :
                                bst_ok ? cyc_q[4:0] : eff_half_q; // [RULE_03]
  wire logic       is_wr_d    = is_rw ? !is_rd : is_wr_q;
  wire logic       live_d     = live_q | is_rw;

  // Tracker registers; only the latest burst is ever shortened
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      live_q     <= 1'b0;
      is_wr_q    <= 1'b0;
      ap_q       <= 1'b0;
      bst_done_q <= 1'b0;
      bank_q     <= '0;
      cyc_q      <= CYC_MAX;
      eff_half_q <= 5'h00;
      bst_cnt_q  <= 8'h00;
    end
    else
    begin
      live_q     <= live_d;
      is_wr_q    <= is_wr_d;
      cyc_q      <= cyc_d;
      eff_half_q <= eff_half_d;                               // [RULE_05]
      if (is_rw)
      begin
        ap_q       <= auto_close_bit;
        bank_q     <= cmd_bank;
        bst_done_q <= 1'b0;                                   // [RULE_08]
      end
      else if (bst_ok)
      begin
        bst_done_q <= 1'b1;
        bst_cnt_q  <= bst_cnt_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Data windows
  // ****************************************************************
  // Each direction keeps two countdowns: clocks until its first data
  // clock and clocks until just past its last one. A newer burst only
  // moves the start when its latency exceeds the clocks left in the older
  // window, so a seamless follow-on never cuts the earlier burst short.
  logic [6:0] rd_on_q, rd_off_q;
  logic [6:0] wr_on_q, wr_off_q;

  wire logic [6:0] rd_lat   = {3'h0, rl};
  wire logic [6:0] wr_lat   = {3'h0, wl};
  wire logic [6:0] half_new = {2'h0, half_prog};
  wire logic       wr_cmd   = is_rw & !is_rd;
  // A stop cuts only the direction of the latest burst
  wire logic       rd_cut   = bst_ok & !is_wr_q;              // [RULE_05]
  wire logic       wr_cut   = bst_ok & is_wr_q;               // [RULE_05]

  // Countdowns rest at zero between bursts
  wire logic [6:0] rd_on_dec  = (rd_on_q == 7'h00) ? 7'h00
                                                   : rd_on_q - 7'h01;
  wire logic [6:0] rd_off_dec = (rd_off_q == 7'h00) ? 7'h00
                                                    : rd_off_q - 7'h01;
  wire logic [6:0] wr_on_dec  = (wr_on_q == 7'h00) ? 7'h00
                                                   : wr_on_q - 7'h01;
  wire logic [6:0] wr_off_dec = (wr_off_q == 7'h00) ? 7'h00
                                                    : wr_off_q - 7'h01;

  // Start moves only when the latency exceeds the clocks left in the older window
  wire logic [6:0] rd_on_d  = (is_rd & (rd_lat > rd_off_dec)) ? rd_lat
                                                              : rd_on_dec;
  wire logic [6:0] wr_on_d  = (wr_cmd & (wr_lat > wr_off_dec)) ? wr_lat
                                                               : wr_on_dec;
  // End: full length on a command, latency after an accepted stop
  wire logic [6:0] rd_off_d = is_rd  ? 7'(rd_lat + half_new) :
                              rd_cut ? rd_lat : rd_off_dec;   // [RULE_03]
  wire logic [6:0] wr_off_d = wr_cmd ? 7'(wr_lat + half_new) :
                              wr_cut ? wr_lat : wr_off_dec;   // [RULE_03]
  wire logic       rd_win_d = (rd_on_d == 7'h00) & (rd_off_d != 7'h00);
  wire logic       wr_win_d = (wr_on_d == 7'h00) & (wr_off_d != 7'h00);

  // Countdown registers and the windows they open
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_on_q        <= 7'h00;
      rd_off_q       <= 7'h00;
      wr_on_q        <= 7'h00;
      wr_off_q       <= 7'h00;
      rd_data_window <= 1'b0;
      wr_data_window <= 1'b0;
    end
    else
    begin
      rd_on_q        <= rd_on_d;
      rd_off_q       <= rd_off_d;
      wr_on_q        <= wr_on_d;
      wr_off_q       <= wr_off_d;
      rd_data_window <= rd_win_d;                             // [RULE_06]
      wr_data_window <= wr_win_d;                             // [RULE_06]
    end
  end

  // ****************************************************************
  // Write data path: masks ride with data, four beats per array write
  // ****************************************************************
  logic [2*DQ_W-1:0]  first_data_q;
  logic [2*LANES-1:0] first_mask_q;
  logic               half_q;

  // A window cycle carries two beats; two cycles make a group of four
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_data_q <= '0;
      first_mask_q <= '0;
      half_q       <= 1'b0;
      arr_wr       <= '0;
    end
    else
    begin
      arr_wr.valid <= 1'b0;
      if (!wr_data_window)
        half_q <= 1'b0;
      else if (!half_q)
      begin
        first_data_q <= {wr_in.data_r, wr_in.data_f};         // [RULE_10]
        first_mask_q <= {wr_in.mask_r, wr_in.mask_f};         // [RULE_10]
        half_q       <= 1'b1;
      end
      else
      begin
        half_q         <= 1'b0;
        arr_wr.valid   <= 1'b1;                               // [RULE_19]
        arr_wr.bank    <= bank_q;
        arr_wr.data    <= {first_data_q, wr_in.data_r, wr_in.data_f};
        arr_wr.byte_en <= ~{first_mask_q, wr_in.mask_r,
                            wr_in.mask_f};                    // [RULE_09]
      end
    end
  end

  // ****************************************************************
  // Auto-close scheduling and bank state
  // ****************************************************************
  wire logic [6:0] half7   = {2'h0, half_prog};
  wire logic [6:0] rd_ap   = (rtp > 4'h2) ? half7 + {3'h0, rtp} - 7'h02
                                          : half7;            // [RULE_24]
  wire logic [6:0] wr_ap   = {3'h0, wl} + half7 + 7'h01
                             + {3'h0, wr_rec};
  wire logic [6:0] ap_load = is_rd ? rd_ap : wr_ap;

  logic [6:0]       ap_cnt_q [NBANK];
  logic [NBANK-1:0] ap_fire;
  logic [NBANK-1:0] pre_hit;

  // Banks hit by an explicit precharge and by an auto-close expiry
  always_comb
  begin
    for (int b = 0; b < NBANK; b++)
    begin
      ap_fire[b] = (ap_cnt_q[b] == 7'h01);                   // [RULE_21]
      pre_hit[b] = is_pre & (all_bank_flag
                   | (cmd_bank == BANK_W'(b)));               // [RULE_12]
    end
  end

  // Per-bank countdown and open state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < NBANK; b++)
        ap_cnt_q[b] <= 7'h00;
      bank_open    <= 8'h00;
      prech_strobe <= 1'b0;
    end
    else
    begin
      prech_strobe <= is_pre | (|ap_fire);
      for (int b = 0; b < NBANK; b++)
      begin
        if (is_rw & auto_close_bit & (cmd_bank == BANK_W'(b)))
          ap_cnt_q[b] <= ap_load;                             // [RULE_21]
        else if (ap_cnt_q[b] != 7'h00)
          ap_cnt_q[b] <= ap_cnt_q[b] - 7'h01;
        if (is_act & (cmd_bank == BANK_W'(b)))
          bank_open[b] <= 1'b1;                               // [RULE_25]
        else if (pre_hit[b] | ap_fire[b])
          bank_open[b] <= 1'b0;                               // [RULE_25]
      end
    end
  end
  // A plain access leaves bank_open untouched                  [RULE_20]

  // ****************************************************************
  // APB slave: zero wait, read data taken in the setup cycle
  // ****************************************************************
  wire logic [9:0]  widx   = paddr[11:2];
  wire logic        setup  = psel & !penable;
  wire logic        access = psel & penable & pready;
  wire logic        mapped = (widx == CFG_IDX) | (widx == STAT_IDX)
                             | (widx == BSTCNT_IDX);
  wire logic [31:0] stat_w = {11'h000, eff_half_q, 4'h0, bst_done_q,
                              is_wr_q, wr_data_window, rd_data_window,
                              bank_open};
  wire logic [31:0] rd_mux = (widx == CFG_IDX)  ? cfg_q :
                             (widx == STAT_IDX) ? stat_w :
                             (widx == BSTCNT_IDX) ? {24'h000000, bst_cnt_q}
                                                  : 32'h0000_0000;

  // Answer in the access phase; config write lands at that edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q   <= CFG_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & !mapped;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      if (access & pwrite & (widx == CFG_IDX))
        cfg_q <= {12'h000, pwdata[19:0]};
    end
  end

endmodule : lpddr2_bst_ctrl
`default_nettype wire

// ==== logic/lpddr2_bst_pkg.sv ====
// Behaviour
// RULE_01 - Burst stop decoded: chip select low, CA0 CA1 high, CA2 CA3 low.
// RULE_02 - Burst stop comes at most burst_length/2 - 1 clocks after command.
// RULE_03 - Effective burst length is twice the clocks from command to stop.
// RULE_04 - Controller spaces read/write turnarounds using effective burst length.
// RULE_05 - Burst stop touches only the most recent read or write burst.
// RULE_06 - Data ends read_latency or write_latency clocks after the stop edge.
// RULE_07 - Burst stop only an even number of clocks after the command.
// RULE_08 - No second burst stop until a new read or write command.
// RULE_09 - One mask per byte lane; a masked byte of a beat is not written.
// RULE_10 - Masks are captured through the same path as write data.
// RULE_11 - Precharge decoded: chip select low, CA0 CA1 high, CA2 low, CA3 high.
// RULE_12 - all_bank_flag closes every bank, else CA9..CA7 select one bank.
// RULE_13 - Controller waits the all-bank or per-bank precharge time.
// RULE_14 - Read to precharge is at least burst_length/2 clocks.
// RULE_15 - Controller waits row_active_min_time before precharging a bank.
// RULE_16 - read_to_precharge_time starts burst_length/2 - 2 clocks after read.
// RULE_17 - Activation waits row_precharge_time after the bank's precharge.
// RULE_18 - Write to precharge is write_latency + BL/2 + 1 + recovery clocks.
// RULE_19 - Array writes go in groups of four beats, after all four latched.
// RULE_20 - auto_close_bit low leaves the bank open after the burst.
// RULE_21 - auto_close_bit high closes the bank internally at earliest moment.
// RULE_22 - Controller closes a bank before opening another row in it.
// RULE_23 - auto_close_bit rides on CA0 at the falling edge of the command.
// RULE_24 - Read auto-close at max(BL/2, BL/2 - 2 + read_to_precharge clocks).
// RULE_25 - Per-bank open state follows activation, precharge and auto-close.
package lpddr2_bst_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int CA_W    = 10;
  localparam int NBANK   = 8;
  localparam int BANK_W  = 3;
  localparam int LANES   = 4;
  localparam int DQ_W    = LANES * 8;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [9:0]  CFG_IDX     = 10'h000;
  localparam logic [9:0]  STAT_IDX    = 10'h001;
  localparam logic [9:0]  BSTCNT_IDX  = 10'h002;
  localparam int          CFG_BL_LSB  = 0;
  localparam int          CFG_RL_LSB  = 4;
  localparam int          CFG_WL_LSB  = 8;
  localparam int          CFG_RTP_LSB = 12;
  localparam int          CFG_WR_LSB  = 16;
  localparam logic [31:0] CFG_RST     = 32'h0006_2361;
  localparam int          ST_RDWIN    = 8;
  localparam int          ST_WRWIN    = 9;
  localparam int          ST_ISWR     = 10;
  localparam int          ST_BSTDONE  = 11;
  localparam int          ST_EFF_LSB  = 16;
  localparam logic [1:0]  BL_CODE_4   = 2'h0;
  localparam logic [1:0]  BL_CODE_8   = 2'h1;
  localparam logic [5:0]  CYC_MAX     = 6'h3F;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic            cs_n;
    logic [CA_W-1:0] ca_r;
    logic [CA_W-1:0] ca_f;
  } ca_word_t;

  typedef struct packed {
    logic [DQ_W-1:0]  data_r;
    logic [DQ_W-1:0]  data_f;
    logic [LANES-1:0] mask_r;
    logic [LANES-1:0] mask_f;
  } wr_pair_t;

  typedef struct packed {
    logic               valid;
    logic [BANK_W-1:0]  bank;
    logic [4*DQ_W-1:0]  data;
    logic [4*LANES-1:0] byte_en;
  } arr_wr_t;

endpackage : lpddr2_bst_pkg
